// ---- hw/ued_dma_port.v ----
// Functional notes
// - fly-by mode with strobes when ack-only clear
// - ack-only mode when configuration bit set
// - one of fourteen endpoints is DMA target
// - DMA interleaves with register endpoint access
// - target index is endpoint number plus one
// - endpoint direction bit sets DMA direction
// - active acknowledge routes access to DMA endpoint
// - single-cycle or burst up to sixteen bytes
// - request, acknowledge, end polarities programmable
// - end pin, counter, short packet terminate
// - request out; ack, end, strobes in
// - request when endpoint holds data to move; IN endpoints request on free space
// - fly-by read drives next data on bus
// - drop request per transfer or burst end
// - ack removal stops driving the bus
// - ack-only uses ack as strobe, ignores strobes
// - end on OUT discards current buffer only
// - end on IN sends partial packet
// - enable loads counter; exhausted count ends
// - clearing enable halts without interrupt
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ued_map.vh"

module ued_dma_port (
   input  wire        clock,
   input  wire        arst_n,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output reg         dmaRequestOut,
   input  wire        dmaAcknowledgeIn,
   input  wire        transferEndIn,
   input  wire        readStrobeN,
   input  wire        writeStrobeN,
   input  wire [15:0] dataIn,
   output reg  [15:0] dataOut,
   output reg         dataOe,
   output wire [3:0]  epIndex,
   output wire        epRead,
   output wire        epWrite,
   output wire [15:0] epWriteData,
   output wire        epWide,
   input  wire [15:0] epReadData,
   input  wire [15:0] epHasData,
   input  wire [15:0] epHasSpace,
   input  wire [15:0] epShortLast,
   output reg         epDiscard,
   output reg         epValidate
);

   localparam [1:0] S_IDLE = 2'b00;
   localparam [1:0] S_REQ  = 2'b01;
   localparam [1:0] S_WAIT = 2'b10;

   reg  [3:0]  hwCfg;
   reg  [8:0]  dmaCfg;
   reg  [15:0] dmaCount;
   reg  [15:0] workCount;
   reg  [15:0] endpointDirection;
   reg  [3:0]  ioSelect;
   reg  [3:0]  stopFlags;
   reg         running;
   reg         enablePrev;
   reg         ackPrev;
   reg         ownsPrev;
   reg         eotPrev;
   reg         strobePrev;
   reg  [15:0] busLatch;
   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [4:0]  beatBytes;
   reg  [31:0] readMux;
   wire [`UED_SYNC_W-1:0] pinSync;

   // byte width of one transfer
   function [4:0] xferBytes;
      input wide;
      begin
         xferBytes = wide ? 5'h02 : 5'h01;
      end
   endfunction

   // pin level that means active under a programmable polarity
   function isActive;
      input pin;
      input polHigh;
      begin
         isActive = (pin == polHigh);
      end
   endfunction

   ued_pin_sync #(
      .W (`UED_SYNC_W)
   ) u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .din    ({dmaAcknowledgeIn, transferEndIn, readStrobeN, writeStrobeN, dataIn}),
      .dout   (pinSync)
   );

   wire [3:0]  dmaIndex  = dmaCfg[`UED_CFG_IDX_MSB:`UED_CFG_IDX_LSB];
   wire        enable    = dmaCfg[`UED_CFG_EN];
   wire        cntEn     = dmaCfg[`UED_CFG_CNTEN];
   wire        shortEn   = dmaCfg[`UED_CFG_SHORTEN];
   wire        burst     = dmaCfg[`UED_CFG_BURST];
   wire        wide      = dmaCfg[`UED_CFG_WIDE];
   wire        ackOnly   = hwCfg[`UED_HW_ACKONLY];
   wire [4:0]  stepBytes = xferBytes(wide);

   wire ackAct = isActive(pinSync[19], hwCfg[`UED_HW_ACKPOL]);
   wire eotAct = isActive(pinSync[18], hwCfg[`UED_HW_EOTPOL]);
   wire rdAct  = ~pinSync[17];
   wire wrAct  = ~pinSync[16];
   wire [15:0] busIn = pinSync[15:0];

   // indices 0 and 1 belong to the fixed control endpoints
   wire idxValid = (dmaIndex >= `UED_IDX_MIN);
   wire dirIn    = endpointDirection[dmaIndex];
   wire epReady  = dirIn ? epHasSpace[dmaIndex] : epHasData[dmaIndex];

   // ack-only mode ignores the strobe pins entirely
   wire strobeAct = ackOnly ? ackAct :
                    (ackAct & (dirIn ? wrAct : rdAct));
   wire strobeEnd = strobePrev & ~strobeAct;
   wire xfer      = strobeEnd & running;

   // the dma endpoint stays selected one cycle past ack to finish the pop
   wire dmaOwns   = ackAct | ackPrev;

   wire eotEvt    = eotAct & ~eotPrev & running;
   wire cntEvt    = xfer & cntEn & (workCount <= {11'h000, stepBytes});
   wire shortEvt  = xfer & shortEn & ~dirIn & epShortLast[dmaIndex];
   wire stopEvt   = eotEvt | cntEvt | shortEvt;
   wire lastBeat  = ~burst | ((beatBytes + stepBytes) >= `UED_BURST_BYTES);

   // apb decode
   wire apbDone   = psel & penable & pready;
   wire isIoData  = (paddr == `UED_ADDR_IODATA);
   wire mapped    = (paddr == `UED_ADDR_HWCFG)  | (paddr == `UED_ADDR_DMACFG) |
                    (paddr == `UED_ADDR_DMACNT) | (paddr == `UED_ADDR_STATUS) |
                    (paddr == `UED_ADDR_ENDPOINT_DIRECTION_BIT)  | (paddr == `UED_ADDR_IOSEL)  |
                    isIoData;
   wire wrStrobe  = apbDone & pwrite & mapped;

   // io data access waits while the dma side holds the endpoint port
   assign pready  = ~(isIoData & (dmaOwns | ownsPrev));
   assign pslverr = apbDone & ~mapped;

   // shared endpoint port
   assign epIndex     = dmaOwns ? dmaIndex : ioSelect;
   assign epRead      = (xfer & ~dirIn) | (apbDone & ~pwrite & isIoData);
   assign epWrite     = (xfer & dirIn) | (wrStrobe & isIoData);
   assign epWriteData = dmaOwns ? busLatch : pwdata[15:0];
   assign epWide      = dmaOwns & wide;

   always @* begin
      readMux = 32'h0000_0000;
      case (paddr)
         `UED_ADDR_HWCFG:  readMux[3:0]  = hwCfg;
         `UED_ADDR_DMACFG: readMux[8:0]  = dmaCfg;
         `UED_ADDR_DMACNT: readMux[15:0] = dmaCount;
         `UED_ADDR_STATUS: begin
            readMux[`UED_ST_SHORTSTOP:`UED_ST_RUNNING] = {stopFlags[3:1], running};
            readMux[31:`UED_ST_CNT_LSB] = workCount;
         end
         `UED_ADDR_ENDPOINT_DIRECTION_BIT:  readMux[15:0] = endpointDirection;
         `UED_ADDR_IOSEL:  readMux[3:0]  = ioSelect;
         `UED_ADDR_IODATA: readMux[15:0] = epReadData;
         default:          readMux = 32'h0000_0000;
      endcase
   end

   // registers written by software
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hwCfg             <= `UED_HW_RST;
         dmaCfg            <= `UED_CFG_RST;
         dmaCount          <= `UED_CNT_RST;
         endpointDirection <= `UED_ENDPOINT_DIRECTION_BIT_RST;
         ioSelect          <= `UED_IOSEL_RST;
      end else if (wrStrobe) begin
         case (paddr)
            `UED_ADDR_HWCFG:  hwCfg             <= pwdata[3:0];
            `UED_ADDR_DMACFG: dmaCfg            <= pwdata[8:0];
            `UED_ADDR_DMACNT: dmaCount          <= pwdata[15:0];
            `UED_ADDR_ENDPOINT_DIRECTION_BIT:  endpointDirection <= pwdata[15:0];
            `UED_ADDR_IOSEL:  ioSelect          <= pwdata[3:0];
            default:          ioSelect          <= ioSelect;
         endcase
      end
   end

   // read data is refreshed until the transfer completes
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~apbDone) begin
         prdata <= readMux;
      end
   end

   // pin history
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ackPrev    <= 1'b0;
         ownsPrev   <= 1'b0;
         eotPrev    <= 1'b0;
         strobePrev <= 1'b0;
         enablePrev <= 1'b0;
      end else begin
         ackPrev    <= ackAct;
         ownsPrev   <= dmaOwns;
         eotPrev    <= eotAct;
         strobePrev <= strobeAct;
         enablePrev <= enable;
      end
   end

   // run control, byte counter and stop reasons
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         running   <= 1'b0;
         workCount <= `UED_CNT_RST;
         stopFlags <= 4'h0;
      end else begin
         if (enable & ~enablePrev) begin
            running   <= idxValid;
            workCount <= dmaCount;
            stopFlags <= 4'h0;
         end else if (~enable) begin
            // plain halt; no stop flag and no interrupt
            running <= 1'b0;
         end else begin
            if (xfer) begin
               // saturates so a short last word cannot wrap the count
               workCount <= (workCount > {11'h000, stepBytes}) ?
                            workCount - {11'h000, stepBytes} : 16'h0000;
            end
            if (stopEvt) begin
               running <= 1'b0;
            end
            // clear wins: no flag is set on the enable edge that clears them
            if (eotEvt) begin
               stopFlags[`UED_ST_EOTSTOP] <= 1'b1;
            end
            if (cntEvt) begin
               stopFlags[`UED_ST_CNTSTOP] <= 1'b1;
            end
            if (shortEvt) begin
               stopFlags[`UED_ST_SHORTSTOP] <= 1'b1;
            end
         end
      end
   end

   // buffer side effects of termination
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         epDiscard  <= 1'b0;
         epValidate <= 1'b0;
      end else begin
         // only the current buffer is dropped; the idle one is left alone
         epDiscard  <= eotEvt & ~dirIn;
         // a partly filled IN buffer is armed for the next token
         epValidate <= (eotEvt | cntEvt) & dirIn;
      end
   end

   // request sequencing
   always @* begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (running & epReady & ~ackAct) begin
               next_state = S_REQ;
            end
         end
         S_REQ: begin
            if (~running) begin
               next_state = S_WAIT;
            end else if (xfer & lastBeat) begin
               next_state = S_WAIT;
            end
         end
         S_WAIT: begin
            if (~ackAct & ~strobeAct) begin
               next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   wire reqNext = (next_state == S_REQ) & running & epReady;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state         <= S_IDLE;
         beatBytes     <= 5'h00;
         dmaRequestOut <= 1'b0;
      end else begin
         state <= next_state;
         if (state != S_REQ) begin
            beatBytes <= 5'h00;
         end else if (xfer) begin
            beatBytes <= beatBytes + stepBytes;
         end
         dmaRequestOut <= reqNext ~^ hwCfg[`UED_HW_REQPOL];
      end
   end

   // data bus toward the external controller
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dataOut  <= 16'h0000;
         dataOe   <= 1'b0;
         busLatch <= 16'h0000;
      end else begin
         if (strobeAct & ~strobePrev) begin
            dataOut <= epReadData;
         end
         // drive only while acknowledged, for a read, while running
         dataOe <= strobeAct & ~dirIn & running;
         if (strobeAct) begin
            busLatch <= busIn;
         end
      end
   end

endmodule // ued_dma_port

`default_nettype wire

// ---- hw/ued_map.vh ----
`ifndef UED_MAP_VH
`define UED_MAP_VH

// register byte addresses
`define UED_ADDR_HWCFG   8'h00
`define UED_ADDR_DMACFG  8'h04
`define UED_ADDR_DMACNT  8'h08
`define UED_ADDR_STATUS  8'h0C
`define UED_ADDR_ENDPOINT_DIRECTION_BIT   8'h10
`define UED_ADDR_IOSEL   8'h14
`define UED_ADDR_IODATA  8'h18

// hardware configuration fields
`define UED_HW_ACKONLY   0
`define UED_HW_REQPOL    1
`define UED_HW_ACKPOL    2
`define UED_HW_EOTPOL    3
`define UED_HW_RST       4'h0

// dma configuration fields
`define UED_CFG_IDX_MSB  3
`define UED_CFG_IDX_LSB  0
`define UED_CFG_EN       4
`define UED_CFG_CNTEN    5
`define UED_CFG_SHORTEN  6
`define UED_CFG_BURST    7
`define UED_CFG_WIDE     8
`define UED_CFG_RST      9'h002

// status fields
`define UED_ST_RUNNING   0
`define UED_ST_EOTSTOP   1
`define UED_ST_CNTSTOP   2
`define UED_ST_SHORTSTOP 3
`define UED_ST_CNT_LSB   16

// other constants
`define UED_CNT_RST      16'h0000
`define UED_ENDPOINT_DIRECTION_BIT_RST    16'h0000
`define UED_IOSEL_RST    4'h2
`define UED_IDX_MIN      4'h2
`define UED_BURST_BYTES  5'h10
`define UED_SYNC_W       20

`endif

// ---- hw/ued_pin_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser; the first stage feeds only the second
module ued_pin_sync #(
   parameter W = 20
) (
   input  wire         clock,
   input  wire         arst_n,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);

   reg [W-1:0] stage1;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= {W{1'b0}};
         dout   <= {W{1'b0}};
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule // ued_pin_sync

`default_nettype wire

// ---- tb/ued_dma_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ued_dma_ctrl_model (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        dmaRequestOut,
   input  wire logic [3:0]  pol,
   input  wire logic        dirIn,
   input  wire logic        slow,
   input  wire logic        endNow,
   input  wire logic [15:0] dataOut,
   input  wire logic        dataOe,
   output wire logic        dmaAcknowledgeIn,
   output wire logic        readStrobeN,
   output wire logic        writeStrobeN,
   output wire logic        transferEndIn,
   output wire logic [15:0] dataIn,
   output var  logic [15:0] lastRead,
   output var  int          xfers
);
   logic        ack = 1'b0;
   logic [15:0] word = 16'h0000;
   assign dmaAcknowledgeIn = ack ~^ pol[2];
   assign transferEndIn    = endNow ~^ pol[3];
   assign readStrobeN      = !(ack && !dirIn && !pol[0]);
   assign writeStrobeN     = !(ack && dirIn && !pol[0]);
   // released bus shows the inverse, so a stale capture cannot pass
   assign dataIn = (ack && dirIn) ? word : ~word;
   initial begin
      lastRead = 16'h0000;
      xfers = 0;
      // the request pin shows its reset level until one edge past release
      wait (arst_n === 1'b1);
      @(posedge clock);
      forever begin
         @(posedge clock);
         if ((dmaRequestOut ~^ pol[1]) === 1'b1 && !endNow) begin
            repeat (slow ? 6 : 0) @(posedge clock);
            ack <= 1'b1;
            repeat (5) @(posedge clock);
            if (!dirIn)
               lastRead = dataOe ? dataOut : ~dataOut;
            ack <= 1'b0;
            word <= word + 16'h0001;
            xfers++;
            // gap keeps strobes at least three cycles apart
            repeat (4) @(posedge clock);
         end
      end
   end
endmodule // ued_dma_ctrl_model
`default_nettype wire

// ---- tb/ued_dma_port_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module ued_dma_port_assertions (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dmaRequestOut,
   input wire logic        dmaAcknowledgeIn,
   input wire logic        dataOe,
   input wire logic [3:0]  epIndex,
   input wire logic        epRead,
   input wire logic        epWrite,
   input wire logic        epDiscard
);
   logic [3:0] hw;
   logic [4:0] cfg;
   logic       wrOk;
   logic       ackAct;
   assign wrOk   = psel && penable && pready && pwrite;
   assign ackAct = dmaAcknowledgeIn ~^ hw[2];
   // copies of the configuration, taken on the edge the registers take them
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hw  <= 4'h0;
         cfg <= 5'h02;
      end else if (wrOk && paddr == 8'h00) begin
         hw <= pwdata[3:0];
      end else if (wrOk && paddr == 8'h04) begin
         cfg <= pwdata[4:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence ackHeld;
      ackAct [*3];
   endsequence
   sequence ackGone;
      !ackAct [*5];
   endsequence
   apb_no_wait_a: assert property (psel && penable && paddr != 8'h18 |-> pready)
      else $error("register access stalled");
   unmapped_err_a: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
      else $error("unmapped access not refused");
   ep_one_way_a: assert property (!(epRead && epWrite))
      else $error("pop and push together");
   discard_pulse_a: assert property (epDiscard |=> !epDiscard)
      else $error("discard longer than a cycle");
   dma_route_a: assert property (ackHeld |-> epIndex == cfg[3:0])
      else $error("ack not routed to dma endpoint");
   oe_release_a: assert property (ackGone |-> !dataOe)
      else $error("bus driven after ack removed");
   oe_cause_a: assert property ($rose(dataOe) |-> $past(ackAct))
      else $error("bus driven without ack");
   req_idle_a: assert property ((!cfg[4] && $stable(hw)) [*3] |-> dmaRequestOut == !hw[1])
      else $error("request active while disabled");
endmodule // ued_dma_port_assertions

bind ued_dma_port ued_dma_port_assertions ued_dma_port_assertions_i (
   .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .dmaRequestOut(dmaRequestOut), .dmaAcknowledgeIn(dmaAcknowledgeIn), .dataOe(dataOe),
   .epIndex(epIndex), .epRead(epRead), .epWrite(epWrite), .epDiscard(epDiscard));
`default_nettype wire

// ---- tb/ued_dma_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ued_dma_port_tb;
   logic        clock, pready, pslverr, err, dataOe, epRead, epWrite, epWide, epDiscard;
   logic        dmaRequestOut, dmaAcknowledgeIn, transferEndIn, readStrobeN, writeStrobeN;
   logic        epValidate;
   logic        arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reqWas = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic [15:0] dataIn, dataOut, epWriteData, lastRead, lastPush;
   logic [15:0] epHasData = 16'h0000, epHasSpace = 16'h0000, epShortLast = 16'h0000;
   logic [3:0]  epIndex;
   logic [3:0]  pol = 4'h0;
   logic [11:0] popCnt = 12'h000;
   logic        dirIn = 1'b0, slow = 1'b0, endNow = 1'b0;
   int          xfers, x0;
   int          pushes = 0, discards = 0, validates = 0, reqFalls = 0, widePushes = 0;
   int          fail_count = 0;
   int          num_checks = 0;

   ued_dma_port ued_dma_port_i (
      .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dmaRequestOut(dmaRequestOut), .dmaAcknowledgeIn(dmaAcknowledgeIn),
      .transferEndIn(transferEndIn), .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
      .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .epIndex(epIndex),
      .epRead(epRead), .epWrite(epWrite), .epWriteData(epWriteData), .epWide(epWide),
      .epReadData({epIndex, popCnt}), .epHasData(epHasData), .epHasSpace(epHasSpace),
      .epShortLast(epShortLast), .epDiscard(epDiscard), .epValidate(epValidate));
   ued_dma_ctrl_model ued_dma_ctrl_model_i (
      .arst_n(arst_n),
      .clock(clock), .dmaRequestOut(dmaRequestOut), .pol(pol), .dirIn(dirIn), .slow(slow),
      .endNow(endNow), .dataOut(dataOut), .dataOe(dataOe), .dmaAcknowledgeIn(dmaAcknowledgeIn),
      .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .transferEndIn(transferEndIn),
      .dataIn(dataIn), .lastRead(lastRead), .xfers(xfers));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // endpoint buffer stand-in: head word carries the index and a pop count
   always @(posedge clock) begin
      if (epRead === 1'b1)
         popCnt <= popCnt + 12'h001;
      if (epWrite === 1'b1)
         lastPush <= epWriteData;
      pushes    += (epWrite === 1'b1);
      widePushes += (epWrite === 1'b1 && epWide === 1'b1);
      discards  += (epDiscard === 1'b1);
      validates += (epValidate === 1'b1);
      reqFalls  += (reqWas && !(dmaRequestOut ~^ pol[1]));
      reqWas    <= (dmaRequestOut ~^ pol[1]);
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // polarity changes only while disabled, spurious request edges are cleared
   task automatic setup(input logic [3:0] h, input logic [15:0] dir, input logic [31:0] c);
      apb(1'b1, 8'h04, 32'h0000_0000);
      apb(1'b1, 8'h00, {28'h000_0000, h});
      // the request pin takes the new level one edge after the register does
      @(posedge clock);
      pol <= h;
      apb(1'b1, 8'h10, {16'h0000, dir});
      dirIn <= dir[c[3:0]];
      repeat (6) @(posedge clock);
      reqFalls = 0;
      x0 = xfers;
      apb(1'b1, 8'h04, c);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      test_done;
   end

   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk("dmacfg reset", rd, 32'h0000_0002);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped refused", err, 1'b1);
      apb(1'b1, 8'h14, 32'h0000_0003);
      slow <= 1'b1;
      epHasData <= 16'h0020;
      setup(4'h6, 16'h0000, 32'h0000_0155);
      wait (xfers == x0 + 2);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("running", rd[0], 1'b1);
      wait (xfers == x0 + 3);
      epHasData <= 16'h0000;
      epShortLast <= 16'h0020;
      repeat (30) @(posedge clock);
      chk("dma read word", lastRead, {4'h5, 12'h002});
      chk("single drops", reqFalls, 3);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("short stop", rd[3:0], 4'b1000);
      apb(1'b1, 8'h04, 32'h0000_0105);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("halted", rd[0], 1'b0);
      slow <= 1'b0;
      epHasSpace <= 16'h0040;
      apb(1'b1, 8'h08, 32'h0000_0010);
      setup(4'h6, 16'h0040, 32'h0000_01B6);
      repeat (300) @(posedge clock);
      chk("pushes", pushes, 8);
      chk("burst drops", reqFalls, 1);
      chk("wide pushes", widePushes, 8);
      chk("last push", lastPush, 16'(x0 + 7));
      chk("validate", validates, 1);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("count stop", rd[2:0], 3'b100);
      epHasData <= 16'h0004;
      setup(4'hD, 16'h0000, 32'h0000_0112);
      wait (xfers == x0 + 2);
      endNow <= 1'b1;
      repeat (8) @(posedge clock);
      endNow <= 1'b0;
      repeat (40) @(posedge clock);
      chk("ack-only word", lastRead, {4'h2, 12'h004});
      chk("stopped", xfers - x0, 2);
      chk("discard", discards, 1);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("end stop", rd[2:0], 3'b010);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk("io read", rd, 32'h0000_3005);
      apb(1'b1, 8'h18, 32'h0000_A5C3);
      @(posedge clock);
      chk("io push", lastPush, 16'hA5C3);
      test_done;
   end
endmodule // ued_dma_port_tb
`default_nettype wire
